// ==== core/ptp_one_step_correction_rewriter.sv ====
// one-step correction rewriter with time counters and port stampers
`timescale 1ns/1ps
`default_nettype none
module ptp_one_step_correction_rewriter
	import ptp_rew_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic rx_sof_pin_i,
	input wire logic tx_sof_pin_i,
	input wire logic [31:0] rx_io_delay_i,
	input wire logic [31:0] tx_io_delay_i,
	input wire port_mode_t rx_port_timing_mode_i,
	input wire port_mode_t tx_port_timing_mode_i,
	input wire delay_cfg_t delay_cfg_i,
	input wire logic [1:0] udp_checksum_inhibit_i,
	input wire frame_req_t req_i,
	output logic req_ready_o,
	output frame_res_t res_o,
	output preamble_t pre_o,
	output ts_push_t ts_push_o,
	output logic [FREE_W-1:0] free_ns_counter_o,
	output logic [TOD_NS_W-1:0] tod_nanoseconds_o,
	output logic [TOD_SEC_W-1:0] tod_seconds_o,
	output logic [CF_W-1:0] combined_ns_full_o,
	output logic [FREE_W-1:0] ingress_stamp_o,
	output logic ingress_stamp_valid_o,
	output logic [FREE_W-1:0] egress_stamp_o,
	output logic egress_stamp_valid_o
);
	port_mode_t rx_mode;
	port_mode_t tx_mode;
	logic taken;
	logic signed [CF_W-1:0] sel_delay;
	logic signed [CF_W-1:0] rx_cf;
	logic signed [CF_W-1:0] next_cf;
	logic [31:0] next_rsrv;
	logic next_rsrv_write;
	logic next_pre_valid;
	preamble_cmd_t next_pre_cmd;
	logic [TOD_NS_W-1:0] tod_ns_diff;
	logic [31:0] rsrv_ns;
	push_state_t push_state;
	logic [FREE_W-1:0] held_ingress_stamp;
	logic [PORT_W-1:0] held_rx_port;
	logic [CF_W-1:0] nsx_low44;

	// a request is taken only when not finishing a two-step pair
	assign taken = ce_i && req_i.valid && req_ready_o;
	assign rx_mode = (rx_port_timing_mode_i == MODE_DISABLED ||
		rx_port_timing_mode_i == MODE_MONITOR) ? MODE_FRONT : rx_port_timing_mode_i;
	assign tx_mode = tx_port_timing_mode_i;
	assign nsx_low44 = {4'h0, combined_ns_full_o[NSX_WRAP_BIT-1:0]};

	// free counter wraps naturally at 2^32
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			free_ns_counter_o <= FREE_RESET;
		end else if (ce_i) begin
			free_ns_counter_o <= free_ns_counter_o + NS_PER_CYCLE;
		end
	end

	// time of day; combined counter advances in step so it equals sec*1e9+ns modulo 2^48
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			tod_nanoseconds_o <= 30'h00000000;
			tod_seconds_o <= 48'h000000000000;
			combined_ns_full_o <= CF_RESET;
		end else if (ce_i) begin
			combined_ns_full_o <= combined_ns_full_o + {16'h0000, NS_PER_CYCLE};
			if (tod_nanoseconds_o >= NS_PER_SEC - NS_PER_CYCLE[TOD_NS_W-1:0]) begin
				tod_nanoseconds_o <= tod_nanoseconds_o + NS_PER_CYCLE[TOD_NS_W-1:0] - NS_PER_SEC;
				tod_seconds_o <= tod_seconds_o + 48'h000000000001;
			end else begin
				tod_nanoseconds_o <= tod_nanoseconds_o + NS_PER_CYCLE[TOD_NS_W-1:0];
			end
		end
	end

	// ingress and egress port stampers
	port_stamp_unit #(
		.SUBTRACT(1'b1)
	) u_rx_stamp (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.sof_pin_i(rx_sof_pin_i),
		.free_ns_i(free_ns_counter_o),
		.io_delay_i(rx_io_delay_i),
		.stamp_o(ingress_stamp_o),
		.stamp_valid_o(ingress_stamp_valid_o)
	);

	port_stamp_unit #(
		.SUBTRACT(1'b0)
	) u_tx_stamp (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.sof_pin_i(tx_sof_pin_i),
		.free_ns_i(free_ns_counter_o),
		.io_delay_i(tx_io_delay_i),
		.stamp_o(egress_stamp_o),
		.stamp_valid_o(egress_stamp_valid_o)
	);

	// single selected delay, sign-extended
	always_comb begin
		case (req_i.dsel)
			DSEL_INGRESS0: sel_delay = CF_W'($signed(delay_cfg_i.ingress0));
			DSEL_INGRESS1: sel_delay = CF_W'($signed(delay_cfg_i.ingress1));
			DSEL_EGRESS: sel_delay = CF_W'($signed(delay_cfg_i.egress));
			default: sel_delay = '0;
		endcase
	end

	// reserved-30 receive difference, modulo one second
	always_comb begin
		rsrv_ns = {2'b00, tod_nanoseconds_o} - req_i.pdu_reserved_bytes;
		if ({2'b00, tod_nanoseconds_o} < req_i.pdu_reserved_bytes) begin
			rsrv_ns = rsrv_ns + {2'b00, NS_PER_SEC};
		end
		tod_ns_diff = rsrv_ns[TOD_NS_W-1:0];
	end

	// ingress half: bring correction up to the rewrite instant
	always_comb begin
		rx_cf = $signed(req_i.cf) + sel_delay;
		case (rx_mode)
			MODE_RESERVED_NS32_MODE: begin
				rx_cf = rx_cf + {16'h0000, combined_ns_full_o[31:0] - req_i.pdu_reserved_bytes};
			end
			MODE_RESERVED_TOD_NS_MODE: begin
				rx_cf = rx_cf + {18'h00000, tod_ns_diff};
			end
			MODE_ADD_SUB_FULL_MODE: begin
				rx_cf = rx_cf + combined_ns_full_o;
			end
			MODE_ADD_SUB_44BIT_MODE: begin
				rx_cf = rx_cf + nsx_low44;
				if (req_i.cf[CF_WRAP_BIT] != combined_ns_full_o[NSX_WRAP_BIT]) begin
					rx_cf = rx_cf + CF_WRAP_ADD;
				end
				rx_cf[CF_WRAP_BIT] = rx_cf[CF_SIGN_BIT];
			end
			default: begin
				rx_cf = rx_cf + {16'h0000, free_ns_counter_o - req_i.internal_header_stamp};
			end
		endcase
	end

	// egress half: prepare payload for partner or ask the port for a delta
	always_comb begin
		next_cf = rx_cf;
		next_rsrv = req_i.pdu_reserved_bytes;
		next_rsrv_write = 1'b0;
		next_pre_valid = 1'b0;
		next_pre_cmd = PRE_CF_ONLY;
		case (tx_mode)
			MODE_FRONT: begin
				next_pre_valid = 1'b1;
			end
			MODE_RESERVED_NS32_MODE: begin
				next_rsrv = combined_ns_full_o[31:0];
				next_rsrv_write = 1'b1;
			end
			MODE_RESERVED_TOD_NS_MODE: begin
				next_rsrv = {2'b00, tod_nanoseconds_o};
				next_rsrv_write = 1'b1;
				next_pre_valid = 1'b1;
				next_pre_cmd = PRE_CORR_AND_RESERVED_UPDATE;
			end
			MODE_ADD_SUB_FULL_MODE: begin
				next_cf = rx_cf - combined_ns_full_o;
			end
			MODE_ADD_SUB_44BIT_MODE: begin
				next_cf = rx_cf - nsx_low44;
				next_cf[CF_WRAP_BIT] = combined_ns_full_o[NSX_WRAP_BIT];
			end
			MODE_MONITOR: begin
				// residence undone so only the selected delay survives when ingress ran in front mode
				next_cf = rx_cf - {16'h0000, free_ns_counter_o - req_i.internal_header_stamp};
			end
			default: begin
				next_cf = req_i.cf;
			end
		endcase
	end

	// result and preamble registers; two-step and disabled leave the frame as it came
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			res_o <= '0;
			pre_o <= '0;
		end else if (ce_i) begin
			res_o.valid <= taken;
			pre_o.valid <= 1'b0;
			if (taken) begin
				res_o.cf <= req_i.cf;
				res_o.pdu_reserved_bytes <= req_i.pdu_reserved_bytes;
				res_o.rsrv_write <= 1'b0;
				res_o.udp_update <= 1'b0;
				res_o.orig_write <= 1'b0;
				res_o.orig_sec <= tod_seconds_o;
				res_o.orig_ns <= tod_nanoseconds_o;
				pre_o.cmd <= next_pre_cmd;
				pre_o.cf <= next_cf;
				pre_o.ref_ns <= free_ns_counter_o;
				if ((req_i.op == OP_ONE_STEP || req_i.op == OP_TOD_WRITE) &&
					tx_mode != MODE_DISABLED) begin
					res_o.cf <= next_cf;
					res_o.pdu_reserved_bytes <= next_rsrv;
					res_o.rsrv_write <= next_rsrv_write;
					res_o.orig_write <= req_i.op == OP_TOD_WRITE;
					pre_o.valid <= next_pre_valid || req_i.op == OP_TOD_WRITE;
					res_o.udp_update <= !((req_i.ip == IP_V4 && udp_checksum_inhibit_i[UDP_INH_V4]) ||
						(req_i.ip == IP_V6 && udp_checksum_inhibit_i[UDP_INH_V6]));
				end
			end
		end
	end

	// two-step: egress entry first, ingress entry on the next cycle; intake stalls meanwhile
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			push_state <= PUSH_IDLE;
			req_ready_o <= 1'b1;
			ts_push_o <= '0;
			held_ingress_stamp <= FREE_RESET;
			held_rx_port <= '0;
		end else if (ce_i) begin
			ts_push_o.valid <= 1'b0;
			case (push_state)
				PUSH_IDLE: begin
					if (taken && req_i.op == OP_TWO_STEP) begin
						ts_push_o.valid <= 1'b1;
						ts_push_o.is_ingress <= 1'b0;
						ts_push_o.port <= req_i.tx_port;
						ts_push_o.stamp <= egress_stamp_o;
						held_ingress_stamp <= req_i.internal_header_stamp;
						held_rx_port <= req_i.rx_port;
						push_state <= PUSH_INGRESS;
						req_ready_o <= 1'b0;
					end
				end
				PUSH_INGRESS: begin
					ts_push_o.valid <= 1'b1;
					ts_push_o.is_ingress <= 1'b1;
					ts_push_o.port <= held_rx_port;
					ts_push_o.stamp <= held_ingress_stamp;
					push_state <= PUSH_IDLE;
					req_ready_o <= 1'b1;
				end
				default: begin
					push_state <= PUSH_IDLE;
					req_ready_o <= 1'b1;
				end
			endcase
		end
	end

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	chk_free_step_wrap: assert property (ce_i |=> free_ns_counter_o ==
		$past(free_ns_counter_o) + NS_PER_CYCLE)
		else $error("free counter did not advance by one period");
	chk_tod_ns_range: assert property (tod_nanoseconds_o < NS_PER_SEC)
		else $error("time of day ns out of range");
	chk_disabled_untouched: assert property (taken && tx_mode == MODE_DISABLED
		|=> res_o.cf == $past(req_i.cf) && !res_o.udp_update && !pre_o.valid && !res_o.rsrv_write)
		else $error("disabled egress modified frame");
	chk_front_to_front: assert property (taken && req_i.op == OP_ONE_STEP &&
		rx_mode == MODE_FRONT && tx_mode == MODE_FRONT |=> pre_o.valid &&
		pre_o.cmd == PRE_CF_ONLY && res_o.cf == $past(req_i.cf) + $past(sel_delay) +
		{16'h0000, $past(free_ns_counter_o) - $past(req_i.internal_header_stamp)})
		else $error("front correction wrong");
	chk_monitor_delay_only: assert property (taken && req_i.op == OP_ONE_STEP &&
		rx_mode == MODE_FRONT && tx_mode == MODE_MONITOR
		|=> res_o.cf == $past(req_i.cf) + $past(sel_delay) && !pre_o.valid)
		else $error("monitor egress kept residence time");
	chk_reserved_tod_ns_mode_request: assert property (taken && req_i.op == OP_ONE_STEP &&
		tx_mode == MODE_RESERVED_TOD_NS_MODE |=> pre_o.valid && pre_o.cmd == PRE_CORR_AND_RESERVED_UPDATE && res_o.rsrv_write &&
		res_o.pdu_reserved_bytes == {2'b00, $past(tod_nanoseconds_o)} &&
		pre_o.ref_ns == $past(free_ns_counter_o))
		else $error("reserved-30 transmit wrong");
	chk_reserved_ns32_mode_write: assert property (taken && req_i.op == OP_ONE_STEP &&
		tx_mode == MODE_RESERVED_NS32_MODE |=> res_o.rsrv_write &&
		res_o.pdu_reserved_bytes == $past(combined_ns_full_o[31:0]) && !pre_o.valid)
		else $error("reserved-32 transmit wrong");
	chk_add_sub_full_mode_pair: assert property (taken && req_i.op == OP_ONE_STEP &&
		rx_mode == MODE_ADD_SUB_FULL_MODE && tx_mode == MODE_ADD_SUB_FULL_MODE
		|=> res_o.cf == $past(req_i.cf) + $past(sel_delay))
		else $error("add-sub-48 round trip not neutral");
	chk_udp_inhibit_v4: assert property (taken && req_i.ip == IP_V4 &&
		udp_checksum_inhibit_i[UDP_INH_V4] |=> !res_o.udp_update)
		else $error("ipv4 checksum update not inhibited");
	chk_two_step_pair: assert property (taken && req_i.op == OP_TWO_STEP |=>
		(ts_push_o.valid && !ts_push_o.is_ingress && !req_ready_o && res_o.cf == $past(req_i.cf))
		and (ce_i |=> ts_push_o.valid && ts_push_o.is_ingress && req_ready_o))
		else $error("two-step push pair broken");
	chk_busy_refuses: assert property (ce_i && req_i.valid && !req_ready_o |=> !res_o.valid)
		else $error("request taken while not ready");
	chk_one_result_each: assert property (ce_i |=> res_o.valid == $past(taken))
		else $error("result pulse does not match taken request");
	chk_udp_inhibit_v6: assert property (taken && req_i.ip == IP_V6 &&
		udp_checksum_inhibit_i[UDP_INH_V6] |=> !res_o.udp_update)
		else $error("ipv6 checksum update not inhibited");
	chk_tod_write_stamp: assert property (taken && req_i.op == OP_TOD_WRITE &&
		tx_mode != MODE_DISABLED |=> res_o.orig_write && pre_o.valid &&
		res_o.orig_ns == $past(tod_nanoseconds_o) && res_o.orig_sec == $past(tod_seconds_o))
		else $error("time of day write wrong");
	chk_add_sub_44bit_mode_wrap_mark: assert property (taken && req_i.op == OP_ONE_STEP &&
		tx_mode == MODE_ADD_SUB_44BIT_MODE |=> res_o.cf[CF_WRAP_BIT] == $past(combined_ns_full_o[NSX_WRAP_BIT]))
		else $error("add-sub-44 wrap mark wrong");
endmodule : ptp_one_step_correction_rewriter
`default_nettype wire

// ==== core/ptp_rew_pkg.sv ====
// shared types and constants for the one-step correction rewriter
package ptp_rew_pkg;
	localparam int CLK_MHZ = 200;
	localparam int CLK_PERIOD_PS = 5000;
	localparam int NS_PER_CYCLE_INT = CLK_PERIOD_PS / 1000;
	localparam logic [31:0] NS_PER_CYCLE = 32'(NS_PER_CYCLE_INT);
	localparam int FREE_W = 32;
	localparam int TOD_NS_W = 30;
	localparam int TOD_SEC_W = 48;
	localparam int CF_W = 48;
	localparam int PORT_W = 4;
	localparam logic [29:0] NS_PER_SEC = 30'h3B9ACA00;
	localparam int CF_WRAP_BIT = 46;
	localparam int CF_SIGN_BIT = 47;
	localparam int NSX_WRAP_BIT = 44;
	localparam logic [47:0] CF_WRAP_ADD = 48'h100000000000;
	localparam int UDP_INH_V4 = 0;
	localparam int UDP_INH_V6 = 1;
	localparam logic [31:0] FREE_RESET = 32'h00000000;
	localparam logic [47:0] CF_RESET = 48'h000000000000;

	typedef enum logic [2:0] {
		MODE_FRONT, MODE_RESERVED_NS32_MODE, MODE_RESERVED_TOD_NS_MODE, MODE_ADD_SUB_FULL_MODE, MODE_ADD_SUB_44BIT_MODE, MODE_MONITOR,
		MODE_DISABLED
	} port_mode_t;
	typedef enum logic [1:0] {OP_ONE_STEP, OP_TWO_STEP, OP_TOD_WRITE, OP_NONE} op_t;
	typedef enum logic [1:0] {DSEL_NONE, DSEL_INGRESS0, DSEL_INGRESS1, DSEL_EGRESS} delay_sel_t;
	typedef enum logic [1:0] {IP_NONE, IP_V4, IP_V6} ip_kind_t;
	typedef enum logic {PRE_CF_ONLY, PRE_CORR_AND_RESERVED_UPDATE} preamble_cmd_t;
	typedef enum logic {PUSH_IDLE, PUSH_INGRESS} push_state_t;

	typedef struct packed {
		logic valid;
		op_t op;
		delay_sel_t dsel;
		ip_kind_t ip;
		logic [PORT_W-1:0] rx_port;
		logic [PORT_W-1:0] tx_port;
		logic [CF_W-1:0] cf;
		logic [FREE_W-1:0] internal_header_stamp;
		logic [31:0] pdu_reserved_bytes;
	} frame_req_t;

	typedef struct packed {
		logic valid;
		logic [CF_W-1:0] cf;
		logic rsrv_write;
		logic [31:0] pdu_reserved_bytes;
		logic udp_update;
		logic orig_write;
		logic [TOD_SEC_W-1:0] orig_sec;
		logic [TOD_NS_W-1:0] orig_ns;
	} frame_res_t;

	typedef struct packed {
		logic valid;
		preamble_cmd_t cmd;
		logic [CF_W-1:0] cf;
		logic [FREE_W-1:0] ref_ns;
	} preamble_t;

	typedef struct packed {
		logic valid;
		logic is_ingress;
		logic [PORT_W-1:0] port;
		logic [FREE_W-1:0] stamp;
	} ts_push_t;

	typedef struct packed {
		logic [31:0] ingress0;
		logic [31:0] ingress1;
		logic [31:0] egress;
	} delay_cfg_t;
endpackage : ptp_rew_pkg

// ==== core/port_stamp_unit.sv ====
// port-module stamper: pin sync, start-of-frame edge, delay-corrected stamp
`timescale 1ns/1ps
`default_nettype none
module port_stamp_unit
	import ptp_rew_pkg::*;
#(
	parameter bit SUBTRACT = 1'b1
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic sof_pin_i,
	input wire logic [FREE_W-1:0] free_ns_i,
	input wire logic [31:0] io_delay_i,
	output logic [FREE_W-1:0] stamp_o,
	output logic stamp_valid_o
);
	logic sync1;
	logic sync2;
	logic sync3;
	logic level;

	// three-stage synchroniser; first stage feeds only the second
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			sync3 <= 1'b0;
		end else if (ce_i) begin
			sync1 <= sof_pin_i;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// level accepted only once stages two and three agree, filtering one-cycle glitches
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			level <= 1'b0;
		end else if (ce_i && sync2 == sync3) begin
			level <= sync3;
		end
	end

	// stamp is a sample of the free counter, less the I/O delay on ingress and plus it on egress
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			stamp_o <= FREE_RESET;
			stamp_valid_o <= 1'b0;
		end else if (ce_i) begin
			stamp_valid_o <= sync2 == sync3 && sync3 && !level;
			if (sync2 == sync3 && sync3 && !level) begin
				stamp_o <= SUBTRACT ? free_ns_i - io_delay_i : free_ns_i + io_delay_i;
			end
		end
	end

	chk_stamp_from_counter: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		ce_i && sync2 == sync3 && sync3 && !level |=> stamp_valid_o &&
		stamp_o == (SUBTRACT ? $past(free_ns_i) - $past(io_delay_i)
		: $past(free_ns_i) + $past(io_delay_i)))
		else $error("port stamp not free counter corrected by delay");
endmodule : port_stamp_unit
`default_nettype wire

// ==== testbench/sof_partner.sv ====
// far-side port model that raises the start-of-frame pins in both directions
`timescale 1ns/1ps
`default_nettype none
module sof_partner (
	input wire logic ref_clk_i,
	output var logic rx_sof_o,
	output var logic tx_sof_o
);
	// pins idle low between frames
	initial begin
		rx_sof_o = 1'b0;
		tx_sof_o = 1'b0;
	end

	// three cycles high so the sync stages agree, three low so frames stay apart
	task send_sof(input bit egress);
		@(posedge ref_clk_i);
		#1;
		if (egress) tx_sof_o = 1'b1;
		else rx_sof_o = 1'b1;
		repeat (3) @(posedge ref_clk_i);
		#1;
		tx_sof_o = 1'b0;
		rx_sof_o = 1'b0;
		repeat (3) @(posedge ref_clk_i);
		#1;
	endtask : send_sof
endmodule : sof_partner
`default_nettype wire

// ==== testbench/ptp_one_step_correction_rewriter_tb.sv ====
// self-checking bench for the one-step correction rewriter
`timescale 1ns/1ps
`default_nettype none
module ptp_one_step_correction_rewriter_tb
	import ptp_rew_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic rx_pin, tx_pin, ready, ivalid, evalid;
	logic [31:0] rx_dly = 32'h00000000;
	logic [31:0] tx_dly = 32'h00000000;
	port_mode_t rx_mode = MODE_FRONT;
	port_mode_t tx_mode = MODE_FRONT;
	delay_cfg_t dcfg = '0;
	logic [1:0] inh = 2'h0;
	frame_req_t req = '0;
	frame_res_t res;
	preamble_t pre;
	ts_push_t push;
	logic [31:0] free, istamp, estamp, last_eg, f, d;
	logic [29:0] tod_ns, tn;
	logic [47:0] tod_sec, comb, cb, ts, e;
	int fails = 0;
	int checks_done = 0;
	int cycles = 0;

	sof_partner partner (.ref_clk_i(ref_clk), .rx_sof_o(rx_pin), .tx_sof_o(tx_pin));

	ptp_one_step_correction_rewriter uut (.ref_clk_i(ref_clk), .rst_i(rst), .ce_i(ce),
		.rx_sof_pin_i(rx_pin), .tx_sof_pin_i(tx_pin), .rx_io_delay_i(rx_dly),
		.tx_io_delay_i(tx_dly), .rx_port_timing_mode_i(rx_mode),
		.tx_port_timing_mode_i(tx_mode), .delay_cfg_i(dcfg), .udp_checksum_inhibit_i(inh),
		.req_i(req), .req_ready_o(ready), .res_o(res), .pre_o(pre), .ts_push_o(push),
		.free_ns_counter_o(free), .tod_nanoseconds_o(tod_ns), .tod_seconds_o(tod_sec),
		.combined_ns_full_o(comb), .ingress_stamp_o(istamp), .ingress_stamp_valid_o(ivalid),
		.egress_stamp_o(estamp), .egress_stamp_valid_o(evalid));

	always #2.5 ref_clk = ~ref_clk;

	// hang guard, far above the few hundred cycles the run needs
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			finish_test();
		end
	end

	task finish_test;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : finish_test

	task chk(input bit ok, input string what);
		checks_done++;
		if (!ok) begin
			fails++;
			$display("ERROR %0t %s", $time, what);
		end
	endtask : chk

	task step;
		@(posedge ref_clk);
		#1;
	endtask : step

	// hold the request until an edge sees ready, grabbing the counters that edge uses;
	// it stands until the next call replaces it, so frames can follow back to back
	task send(input frame_req_t r);
		req = r;
		while (ready !== 1'b1) step();
		f = free;
		cb = comb;
		tn = tod_ns;
		ts = tod_sec;
		step();
	endtask : send

	// selected delay, ingress half, then egress half; disabled egress or no action wins
	function automatic logic [47:0] exp_cf(input frame_req_t r, input logic [31:0] dv);
		logic [47:0] c;
		logic [30:0] t;
		if (tx_mode == MODE_DISABLED || r.op == OP_NONE) return r.cf;
		c = r.cf + ((r.dsel != DSEL_NONE) ? {{16{dv[31]}}, dv} : 48'h000000000000);
		t = {1'b0, tn} + {1'b0, NS_PER_SEC} - {1'b0, r.pdu_reserved_bytes[29:0]};
		if (t >= {1'b0, NS_PER_SEC}) t = t - {1'b0, NS_PER_SEC};
		case (rx_mode)
			MODE_RESERVED_NS32_MODE: c = c + {16'h0000, cb[31:0] - r.pdu_reserved_bytes};
			MODE_RESERVED_TOD_NS_MODE: c = c + {17'h00000, t};
			MODE_ADD_SUB_FULL_MODE: c = c + cb;
			MODE_ADD_SUB_44BIT_MODE: begin
				c = c + {4'h0, cb[43:0]};
				if (r.cf[46] !== cb[44]) c = c + CF_WRAP_ADD;
				c[46] = c[47];
			end
			default: c = c + {16'h0000, f - r.internal_header_stamp};
		endcase
		case (tx_mode)
			MODE_ADD_SUB_FULL_MODE: c = c - cb;
			MODE_ADD_SUB_44BIT_MODE: begin
				c = c - {4'h0, cb[43:0]};
				c[46] = cb[44];
			end
			MODE_MONITOR: c = c - {16'h0000, f - r.internal_header_stamp};
			default: ;
		endcase
		return c;
	endfunction : exp_cf

	initial begin
		frame_req_t r;
		bit eg, udp, act, ok;
		void'($urandom(32'h38E0));
		repeat (6) @(posedge ref_clk);
		#1;
		chk(free === FREE_RESET && ready === 1'b1 && res.valid === 1'b0, "reset state");
		rst = 1'b0;
		// counters advance five per enabled cycle and freeze with the enable low
		f = free;
		cb = comb;
		tn = tod_ns;
		repeat (10) step();
		chk(free === f + 32'd50, "free counter rate");
		chk(comb === cb + 48'd50 && tod_ns === tn + 30'd50, "time of day rate");
		f = free;
		ce = 1'b0;
		repeat (4) step();
		chk(free === f, "enable freeze");
		ce = 1'b1;
		$display("test counters done");
		// stamps: three edges after the pin is first sampled, delay-corrected
		for (int n = 0; n < 6; n++) begin
			eg = n[0];
			rx_dly = $urandom_range(2000, 0); // shifter state already folded in by software
			tx_dly = $urandom_range(2000, 0);
			fork
				partner.send_sof(eg);
				begin
					repeat (5) @(posedge ref_clk);
					#1;
					if (eg) ok = evalid === 1'b1 && estamp === free - 32'd5 + tx_dly;
					else ok = ivalid === 1'b1 && istamp === free - 32'd5 - rx_dly;
					chk(ok, eg ? "egress stamp" : "ingress stamp");
					if (eg) last_eg = free - 32'd5 + tx_dly;
				end
			join
		end
		$display("test stamps done");
		// random frames over randomly drawn mode pairs, back to back, two-step among them
		for (int n = 0; n < 120; n++) begin
			rx_mode = port_mode_t'($urandom_range(6, 0));
			tx_mode = port_mode_t'($urandom_range(6, 0));
			inh = 2'($urandom);
			dcfg = {$urandom, $urandom, $urandom};
			r = '0;
			r.valid = 1'b1;
			r.op = op_t'($urandom_range(3, 0));
			r.dsel = delay_sel_t'($urandom_range(3, 0));
			r.ip = ip_kind_t'($urandom_range(2, 0));
			r.rx_port = 4'($urandom);
			r.tx_port = 4'($urandom);
			r.cf = 48'({$urandom, $urandom});
			r.internal_header_stamp = $urandom;
			r.pdu_reserved_bytes = $urandom_range(999999999, 0);
			d = (r.dsel == DSEL_INGRESS0) ? dcfg.ingress0 :
				(r.dsel == DSEL_INGRESS1) ? dcfg.ingress1 : dcfg.egress;
			send(r);
			if (r.op == OP_TWO_STEP) begin
				for (int k = 0; k < 3 && push.valid !== 1'b1; k++) step();
				ok = push.valid === 1'b1 && push.is_ingress === 1'b0;
				ok = ok && push.port === r.tx_port && push.stamp === last_eg;
				chk(ok, "egress entry");
				chk(res.cf === r.cf && ready === 1'b0, "two-step field untouched");
				// the held request meets ready low at this edge and must be refused
				step();
				ok = push.valid === 1'b1 && push.is_ingress === 1'b1 && push.port === r.rx_port;
				chk(ok && push.stamp === r.internal_header_stamp, "ingress entry");
				chk(res.valid === 1'b0, "request refused after two-step");
				continue;
			end
			for (int k = 0; k < 3 && res.valid !== 1'b1; k++) step();
			act = r.op != OP_NONE && tx_mode != MODE_DISABLED;
			e = exp_cf(r, d);
			ok = res.valid === 1'b1 && res.cf === e;
			chk(ok, "corrected field");
			udp = act && !(r.ip == IP_V4 && inh[UDP_INH_V4]);
			udp = udp && !(r.ip == IP_V6 && inh[UDP_INH_V6]);
			chk(res.udp_update === udp, "checksum flag");
			ok = res.rsrv_write === 1'b1 && res.pdu_reserved_bytes === cb[31:0];
			if (act && tx_mode == MODE_RESERVED_NS32_MODE) chk(ok, "reserved low32");
			ok = res.pdu_reserved_bytes === {2'b00, tn} && pre.valid === 1'b1;
			ok = ok && pre.cmd === PRE_CORR_AND_RESERVED_UPDATE && pre.ref_ns === f;
			if (act && tx_mode == MODE_RESERVED_TOD_NS_MODE) chk(ok, "reserved tod");
			ok = pre.valid === 1'b1 && pre.cmd === PRE_CF_ONLY && pre.cf === e && pre.ref_ns === f;
			if (act && tx_mode == MODE_FRONT) chk(ok, "front preamble");
			if (!act) chk(pre.valid === 1'b0 && res.rsrv_write === 1'b0, "frame untouched");
			ok = res.orig_write === 1'b1 && res.orig_ns === tn && res.orig_sec === ts;
			if (act && r.op == OP_TOD_WRITE) chk(ok && pre.valid === 1'b1, "time write");
		end
		$display("test frames done");
		finish_test();
	end
endmodule : ptp_one_step_correction_rewriter_tb
`default_nettype wire
